// >>> verilog/cskb_pkg.sv
// ****************************************************************
// constants shared by the compare / skip / branch unit
// ****************************************************************
package cskb_pkg;
   localparam int DW = 8;
   localparam int RF_AW = 5;
   localparam int ST_AW = 8;
   localparam int PC_W = 16;
   localparam int IO_AW = 5;
   localparam int INS_W = 27;

   // instruction word fields
   localparam int INS_OP_LSB = 0;
   localparam int INS_RD_LSB = 5;
   localparam int INS_RR_LSB = 10;
   localparam int INS_BIT_LSB = 15;
   localparam int INS_K_LSB = 18;
   localparam int INS_TWO_WORD = 26;

   // opcodes: compares, skips, branches, stack, debug
   localparam logic [4:0] OP_COMPARE_REGS = 5'h00;
   localparam logic [4:0] OP_COMPARE_REGS_WITH_CARRY = 5'h01;
   localparam logic [4:0] OP_COMPARE_IMMEDIATE = 5'h02;
   localparam logic [4:0] OP_COMPARE_SKIP_EQUAL = 5'h03;
   localparam logic [4:0] OP_SKIP_REG_BIT_CLEAR = 5'h04;
   localparam logic [4:0] OP_SKIP_REG_BIT_SET = 5'h05;
   localparam logic [4:0] OP_SKIP_IO_BIT_CLEAR = 5'h06;
   localparam logic [4:0] OP_SKIP_IO_BIT_SET = 5'h07;
   localparam logic [4:0] OP_BRANCH_STATUS_BIT_SET = 5'h08;
   localparam logic [4:0] OP_BRANCH_STATUS_BIT_CLEAR = 5'h09;
   localparam logic [4:0] OP_BRANCH_EQUAL = 5'h0A;
   localparam logic [4:0] OP_BRANCH_NOT_EQUAL = 5'h0B;
   localparam logic [4:0] OP_BRANCH_CARRY_SET = 5'h0C;
   localparam logic [4:0] OP_BRANCH_CARRY_CLEAR = 5'h0D;
   localparam logic [4:0] OP_BRANCH_SAME_OR_HIGHER = 5'h0E;
   localparam logic [4:0] OP_BRANCH_LOWER = 5'h0F;
   localparam logic [4:0] OP_BRANCH_MINUS = 5'h10;
   localparam logic [4:0] OP_BRANCH_PLUS = 5'h11;
   localparam logic [4:0] OP_BRANCH_SIGNED_GE = 5'h12;
   localparam logic [4:0] OP_BRANCH_SIGNED_LT = 5'h13;
   localparam logic [4:0] OP_BRANCH_HALF_CARRY_SET = 5'h14;
   localparam logic [4:0] OP_BRANCH_TRANSFER_BIT_SET = 5'h15;
   localparam logic [4:0] OP_BRANCH_TRANSFER_BIT_CLEAR = 5'h16;
   localparam logic [4:0] OP_PUSH = 5'h17;
   localparam logic [4:0] OP_POP = 5'h18;
   localparam logic [4:0] OP_DEBUG_BREAK = 5'h19;

   // status_flag_register bit positions
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;

   // register word indices on the avalon slave
   localparam logic [3:0] REG_INSTR = 4'h0;
   localparam logic [3:0] REG_PC = 4'h1;
   localparam logic [3:0] REG_STATUS_FLAGS = 4'h2;
   localparam logic [3:0] REG_STACK_PTR = 4'h3;
   localparam logic [3:0] REG_GPR_SEL = 4'h4;
   localparam logic [3:0] REG_GPR_DATA = 4'h5;
   localparam logic [3:0] REG_CYCLES = 4'h6;
   localparam logic [3:0] REG_BUSY = 4'h7;

   // reset values and cycle counts
   localparam logic [15:0] PC_RST = 16'h0000;
   localparam logic [7:0] SP_RST = 8'hFF;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [1:0] EXTRA_NONE = 2'h0;
   localparam logic [1:0] EXTRA_ONE = 2'h1;
   localparam logic [1:0] EXTRA_TWO = 2'h2;

   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_EXEC, ST_MORE} cskb_state_t;
endpackage

// >>> verilog/cskb_mem.sv
`timescale 1ns/1ps
// ****************************************************************
// small memory, one write port, two registered read ports
// ****************************************************************
module cskb_mem #(
   parameter int AW = 5,
   parameter int DW = 8
) (
   input wire logic clk,
   input wire logic en,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic [AW-1:0] ra_addr,
   output logic [DW-1:0] ra_data_q,
   input wire logic [AW-1:0] rb_addr,
   output logic [DW-1:0] rb_data_q
);
   logic [DW-1:0] mem [2**AW];

   // read data come a cycle after the address; write-first is not offered
   always_ff @(posedge clk)
   begin
      if (en)
      begin
         if (we)
            mem[waddr] <= wdata;
         ra_data_q <= mem[ra_addr];
         rb_data_q <= mem[rb_addr];
      end
   end
endmodule // cskb_mem

// >>> verilog/cskb_cmp.sv
`timescale 1ns/1ps
// ****************************************************************
// subtract without store, flags only
// ****************************************************************
module cskb_cmp (
   input wire logic [7:0] op_a,
   input wire logic [7:0] op_b,
   input wire logic carry_in,
   output logic flag_z,
   output logic flag_n,
   output logic flag_v,
   output logic flag_c,
   output logic flag_h
);
   logic [8:0] diff;
   logic [7:0] r;

   // borrow out of bit 7 is the carry, out of bit 3 the half carry
   assign diff = {1'h0, op_a} - {1'h0, op_b} - {8'h00, carry_in};
   assign r = diff[7:0];
   assign flag_z = (r == 8'h00);
   assign flag_n = r[7];
   assign flag_v = (op_a[7] & ~op_b[7] & ~r[7]) | (~op_a[7] & op_b[7] & r[7]);
   assign flag_c = diff[8];
   assign flag_h = (~op_a[3] & op_b[3]) | (op_b[3] & r[3]) | (r[3] & ~op_a[3]);
endmodule // cskb_cmp

// >>> verilog/cskb_unit.sv
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
// Summary of operation
// - equal registers skip next, flags untouched
// - compare subtracts, sets five flags, one cycle
// - carry compare also subtracts carry flag
// - register bit clear skips next instruction
// - register bit set skips next instruction
// - io bit clear skips next instruction
// - io bit set skips next instruction
// - status bit set branches relative
// - status bit clear branches relative
// - equal/not-equal branch on zero flag
// - carry set/clear branch on carry
// - same-or-higher/lower branch on carry
// - minus/plus branch on negative flag
// - signed branches on negative xor overflow
// - half carry set branches relative
// - transfer bit set/clear branches relative
// - push stores register, two cycles
// - pop loads register, two cycles
// - break only signals debug, flags kept
module cskb_unit (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [4:0] io_addr,
   input wire logic [7:0] io_data,
   output logic debug_break
);
   // ****************************************************************
   // state
   // ****************************************************************
   cskb_pkg::cskb_state_t state_q, state_d;
   logic [26:0] instr_q;
   logic [15:0] pc_q, pc_d;
   logic [7:0] flags_q, flags_d;
   logic [7:0] sp_q;
   logic [4:0] gpr_sel_q;
   logic gpr_ok_q;
   logic [1:0] more_q, more_d;
   logic [3:0] cyc_q;
   logic ack_q;
   logic [31:0] rdata_q;
   logic brk_q;
   logic [4:0] io_addr_q;

   // ****************************************************************
   // bus decode
   // ****************************************************************
   logic req, take, is_idle, needs_idle, rd_gpr, ready_now;
   logic wr_instr, wr_pc, wr_flags, wr_sp, wr_sel, wr_gpr;
   logic [31:0] rmux;

   // a request is answered one cycle after it is seen, once ready
   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~(ack_q & clk_en);
   assign take = req & ack_q & clk_en;
   assign is_idle = (state_q == cskb_pkg::ST_IDLE);
   assign rd_gpr = avs_read & (avs_address == cskb_pkg::REG_GPR_DATA);
   assign needs_idle = rd_gpr | (avs_write & (avs_address <= cskb_pkg::REG_STACK_PTR))
      | (avs_write & (avs_address == cskb_pkg::REG_GPR_DATA));
   // stalling here keeps software from racing the executing instruction
   assign ready_now = ~needs_idle | (is_idle & (~rd_gpr | gpr_ok_q));
   assign wr_instr = take & avs_write & (avs_address == cskb_pkg::REG_INSTR);
   assign wr_pc = take & avs_write & (avs_address == cskb_pkg::REG_PC);
   assign wr_flags = take & avs_write & (avs_address == cskb_pkg::REG_STATUS_FLAGS);
   assign wr_sp = take & avs_write & (avs_address == cskb_pkg::REG_STACK_PTR);
   assign wr_sel = take & avs_write & (avs_address == cskb_pkg::REG_GPR_SEL);
   assign wr_gpr = take & avs_write & (avs_address == cskb_pkg::REG_GPR_DATA);

   // ****************************************************************
   // instruction fields and operands
   // ****************************************************************
   logic [4:0] i_op, i_rd, i_rr;
   logic [2:0] i_bit;
   logic [7:0] i_k, rf_a, rf_b, st_q, op_b;
   logic i_two, ex, is_skip, is_branch, is_cmp, rf_we, st_we;
   logic [4:0] rf_waddr, rf_raddr;
   logic [7:0] rf_wdata, st_raddr;
   logic cmp_z, cmp_n, cmp_v, cmp_c, cmp_h;
   logic [15:0] br_target;

   assign i_op = instr_q[cskb_pkg::INS_OP_LSB +: 5];
   assign i_rd = instr_q[cskb_pkg::INS_RD_LSB +: 5];
   assign i_rr = instr_q[cskb_pkg::INS_RR_LSB +: 5];
   assign i_bit = instr_q[cskb_pkg::INS_BIT_LSB +: 3];
   assign i_k = instr_q[cskb_pkg::INS_K_LSB +: 8];
   assign i_two = instr_q[cskb_pkg::INS_TWO_WORD];
   assign ex = (state_q == cskb_pkg::ST_EXEC);
   assign is_cmp = (i_op <= cskb_pkg::OP_COMPARE_IMMEDIATE);
   assign is_skip = (i_op >= cskb_pkg::OP_COMPARE_SKIP_EQUAL)
      & (i_op <= cskb_pkg::OP_SKIP_IO_BIT_SET);
   assign is_branch = (i_op >= cskb_pkg::OP_BRANCH_STATUS_BIT_SET)
      & (i_op <= cskb_pkg::OP_BRANCH_TRANSFER_BIT_CLEAR);
   // immediate form compares against the k field
   assign op_b = (i_op == cskb_pkg::OP_COMPARE_IMMEDIATE) ? i_k : rf_b;
   // relative offset is a signed 7-bit value
   assign br_target = pc_q + {{9{i_k[6]}}, i_k[6:0]} + 16'h0001;

   // read port a serves software while idle, the rd operand otherwise
   assign rf_raddr = is_idle ? gpr_sel_q : i_rd;
   // pop lands in the register file in its second cycle
   assign rf_we = wr_gpr | ((state_q == cskb_pkg::ST_MORE) & (i_op == cskb_pkg::OP_POP));
   assign rf_waddr = wr_gpr ? gpr_sel_q : i_rd;
   assign rf_wdata = wr_gpr ? avs_writedata[7:0] : st_q;
   assign st_we = ex & (i_op == cskb_pkg::OP_PUSH);
   assign st_raddr = sp_q + 8'h01;

   cskb_mem #(.AW(cskb_pkg::RF_AW), .DW(cskb_pkg::DW)) u_regs (
      .clk(core_clk),
      .en(clk_en),
      .we(rf_we),
      .waddr(rf_waddr),
      .wdata(rf_wdata),
      .ra_addr(rf_raddr),
      .ra_data_q(rf_a),
      .rb_addr(i_rr),
      .rb_data_q(rf_b)
   );

   cskb_mem #(.AW(cskb_pkg::ST_AW), .DW(cskb_pkg::DW)) u_stack (
      .clk(core_clk),
      .en(clk_en),
      .we(st_we),
      .waddr(sp_q),
      .wdata(rf_a),
      .ra_addr(st_raddr),
      .ra_data_q(st_q),
      .rb_addr(st_raddr),
      .rb_data_q()
   );

   cskb_cmp u_cmp (
      .op_a(rf_a),
      .op_b(op_b),
      .carry_in((i_op == cskb_pkg::OP_COMPARE_REGS_WITH_CARRY) & flags_q[cskb_pkg::FLAG_C]),
      .flag_z(cmp_z),
      .flag_n(cmp_n),
      .flag_v(cmp_v),
      .flag_c(cmp_c),
      .flag_h(cmp_h)
   );

   // ****************************************************************
   // conditions
   // ****************************************************************
   // branch condition per opcode from the status flags
   function automatic logic br_cond(input logic [4:0] op, input logic [7:0] sr,
                                    input logic [2:0] sel);
      case (op)
         cskb_pkg::OP_BRANCH_STATUS_BIT_SET: br_cond = sr[sel];
         cskb_pkg::OP_BRANCH_STATUS_BIT_CLEAR: br_cond = ~sr[sel];
         cskb_pkg::OP_BRANCH_EQUAL: br_cond = sr[cskb_pkg::FLAG_Z];
         cskb_pkg::OP_BRANCH_NOT_EQUAL: br_cond = ~sr[cskb_pkg::FLAG_Z];
         cskb_pkg::OP_BRANCH_CARRY_SET: br_cond = sr[cskb_pkg::FLAG_C];
         cskb_pkg::OP_BRANCH_CARRY_CLEAR: br_cond = ~sr[cskb_pkg::FLAG_C];
         cskb_pkg::OP_BRANCH_SAME_OR_HIGHER: br_cond = ~sr[cskb_pkg::FLAG_C];
         cskb_pkg::OP_BRANCH_LOWER: br_cond = sr[cskb_pkg::FLAG_C];
         cskb_pkg::OP_BRANCH_MINUS: br_cond = sr[cskb_pkg::FLAG_N];
         cskb_pkg::OP_BRANCH_PLUS: br_cond = ~sr[cskb_pkg::FLAG_N];
         cskb_pkg::OP_BRANCH_SIGNED_GE:
            br_cond = ~(sr[cskb_pkg::FLAG_N] ^ sr[cskb_pkg::FLAG_V]);
         cskb_pkg::OP_BRANCH_SIGNED_LT:
            br_cond = sr[cskb_pkg::FLAG_N] ^ sr[cskb_pkg::FLAG_V];
         cskb_pkg::OP_BRANCH_HALF_CARRY_SET: br_cond = sr[cskb_pkg::FLAG_H];
         cskb_pkg::OP_BRANCH_TRANSFER_BIT_SET: br_cond = sr[cskb_pkg::FLAG_T];
         cskb_pkg::OP_BRANCH_TRANSFER_BIT_CLEAR: br_cond = ~sr[cskb_pkg::FLAG_T];
         default: br_cond = 1'h0;
      endcase
   endfunction

   logic skip_hit, br_hit;

   // skip tests: register pair, register bit, io bit
   always_comb
   begin
      case (i_op)
         cskb_pkg::OP_COMPARE_SKIP_EQUAL: skip_hit = (rf_a == rf_b);
         cskb_pkg::OP_SKIP_REG_BIT_CLEAR: skip_hit = ~rf_a[i_bit];
         cskb_pkg::OP_SKIP_REG_BIT_SET: skip_hit = rf_a[i_bit];
         cskb_pkg::OP_SKIP_IO_BIT_CLEAR: skip_hit = ~io_data[i_bit];
         cskb_pkg::OP_SKIP_IO_BIT_SET: skip_hit = io_data[i_bit];
         default: skip_hit = 1'h0;
      endcase
   end
   assign br_hit = is_branch & br_cond(i_op, flags_q, i_bit);

   // ****************************************************************
   // execute decisions
   // ****************************************************************
   // program counter, flags and extra cycles decided in the first cycle
   always_comb
   begin
      pc_d = pc_q + 16'h0001;
      more_d = cskb_pkg::EXTRA_NONE;
      flags_d = flags_q;
      if (is_skip & skip_hit)
      begin
         pc_d = pc_q + (i_two ? 16'h0003 : 16'h0002);
         more_d = i_two ? cskb_pkg::EXTRA_TWO : cskb_pkg::EXTRA_ONE;
      end
      else if (br_hit)
      begin
         pc_d = br_target;
         more_d = cskb_pkg::EXTRA_ONE;
      end
      else if ((i_op == cskb_pkg::OP_PUSH) | (i_op == cskb_pkg::OP_POP))
         more_d = cskb_pkg::EXTRA_ONE;
      if (is_cmp)
      begin
         flags_d[cskb_pkg::FLAG_Z] = cmp_z;
         flags_d[cskb_pkg::FLAG_N] = cmp_n;
         flags_d[cskb_pkg::FLAG_V] = cmp_v;
         flags_d[cskb_pkg::FLAG_C] = cmp_c;
         flags_d[cskb_pkg::FLAG_H] = cmp_h;
      end
   end

   // sequencer: idle, operand read, first cycle, extra cycles
   always_comb
   begin
      case (state_q)
         cskb_pkg::ST_IDLE: state_d = wr_instr ? cskb_pkg::ST_READ : cskb_pkg::ST_IDLE;
         cskb_pkg::ST_READ: state_d = cskb_pkg::ST_EXEC;
         cskb_pkg::ST_EXEC:
            state_d = (more_d == cskb_pkg::EXTRA_NONE) ? cskb_pkg::ST_IDLE : cskb_pkg::ST_MORE;
         cskb_pkg::ST_MORE:
            state_d = (more_q == cskb_pkg::EXTRA_ONE) ? cskb_pkg::ST_IDLE : cskb_pkg::ST_MORE;
         default: state_d = cskb_pkg::ST_IDLE;
      endcase
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   // control flow state
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         state_q <= cskb_pkg::ST_IDLE;
         more_q <= cskb_pkg::EXTRA_NONE;
         cyc_q <= 4'h0;
         brk_q <= 1'h0;
      end
      else if (clk_en)
      begin
         state_q <= state_d;
         more_q <= ex ? more_d : more_q - {1'h0, state_q == cskb_pkg::ST_MORE};
         cyc_q <= wr_instr ? 4'h0 : cyc_q + {3'h0, ex | (state_q == cskb_pkg::ST_MORE)};
         brk_q <= ex & (i_op == cskb_pkg::OP_DEBUG_BREAK);
      end
   end

   // architectural state, software writes only while idle
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         pc_q <= cskb_pkg::PC_RST;
         flags_q <= cskb_pkg::FLAGS_RST;
         sp_q <= cskb_pkg::SP_RST;
      end
      else if (clk_en)
      begin
         pc_q <= wr_pc ? avs_writedata[15:0] : (ex ? pc_d : pc_q);
         flags_q <= wr_flags ? avs_writedata[7:0] : (ex ? flags_d : flags_q);
         if (wr_sp)
            sp_q <= avs_writedata[7:0];
         else if (st_we)
            sp_q <= sp_q - 8'h01;
         else if (ex & (i_op == cskb_pkg::OP_POP))
            sp_q <= st_raddr;
      end
   end

   // bus side registers
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         instr_q <= 27'h0000000;
         gpr_sel_q <= 5'h00;
         gpr_ok_q <= 1'h0;
         ack_q <= 1'h0;
         rdata_q <= 32'h00000000;
         io_addr_q <= 5'h00;
      end
      else if (clk_en)
      begin
         if (wr_instr)
         begin
            instr_q <= avs_writedata[26:0];
            io_addr_q <= avs_writedata[cskb_pkg::INS_RD_LSB +: 5];
         end
         if (wr_sel)
            gpr_sel_q <= avs_writedata[4:0];
         // read port data are stale for a cycle after any change
         gpr_ok_q <= ~(wr_sel | rf_we | ~is_idle);
         ack_q <= req & ~ack_q & ready_now;
         if (req & ~ack_q & ready_now)
            rdata_q <= rmux;
      end
   end

   // read multiplexer, unmapped words read zero
   always_comb
   begin
      case (avs_address)
         cskb_pkg::REG_INSTR: rmux = {5'h00, instr_q};
         cskb_pkg::REG_PC: rmux = {16'h0000, pc_q};
         cskb_pkg::REG_STATUS_FLAGS: rmux = {24'h000000, flags_q};
         cskb_pkg::REG_STACK_PTR: rmux = {24'h000000, sp_q};
         cskb_pkg::REG_GPR_SEL: rmux = {27'h0000000, gpr_sel_q};
         cskb_pkg::REG_GPR_DATA: rmux = {24'h000000, rf_a};
         cskb_pkg::REG_CYCLES: rmux = {28'h0000000, cyc_q};
         cskb_pkg::REG_BUSY: rmux = {31'h00000000, ~is_idle};
         default: rmux = 32'h00000000;
      endcase
   end

   assign avs_readdata = rdata_q;
   assign io_addr = io_addr_q;
   assign debug_break = brk_q;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst || !clk_en);

   cmp_one_cycle_a: assert property (ex && (i_op == cskb_pkg::OP_COMPARE_REGS)
      |=> is_idle && (cyc_q == 4'h1)) else $error("compare not single cycle");
   carry_cmp_a: assert property (ex && (i_op == cskb_pkg::OP_COMPARE_REGS_WITH_CARRY)
      |=> flags_q[cskb_pkg::FLAG_C] == $past(cmp_c)) else $error("carry compare flag");
   skip_flags_a: assert property (ex && is_skip
      |=> flags_q == $past(flags_q)) else $error("skip changed flags");
   skip_three_a: assert property (ex && is_skip && skip_hit && i_two
      |=> (pc_q == $past(pc_q) + 16'h0003) ##2 is_idle) else $error("long skip");
   branch_pc_a: assert property (ex && br_hit
      |=> (pc_q == $past(br_target)) ##1 is_idle) else $error("taken branch");
   branch_miss_a: assert property (ex && is_branch && !br_hit
      |=> is_idle && (pc_q == $past(pc_q) + 16'h0001)) else $error("untaken branch");
   push_two_a: assert property (ex && (i_op == cskb_pkg::OP_PUSH)
      |-> st_we ##1 (state_q == cskb_pkg::ST_MORE) ##1 is_idle) else $error("push");
   pop_load_a: assert property ((state_q == cskb_pkg::ST_MORE)
      && (i_op == cskb_pkg::OP_POP)
      |-> rf_we && (rf_waddr == i_rd) && (rf_wdata == st_q)) else $error("pop load");
   break_pulse_a: assert property (ex && (i_op == cskb_pkg::OP_DEBUG_BREAK)
      |=> debug_break && (flags_q == $past(flags_q))) else $error("break pulse");
endmodule // cskb_unit

// >>> testbench/test_cskb_unit.sv
`timescale 1ns/1ps
// ****************************************************************
// self-checking bench for the compare / skip / branch unit
// ****************************************************************
module test_cskb_unit;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic clk_en = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [4:0] io_addr;
   logic [7:0] io_data = 8'h00;
   logic debug_break;
   int num_errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   int breaks = 0;
   logic [31:0] rd_q;

   cskb_unit i_cskb_unit (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .io_addr(io_addr), .io_data(io_data),
      .debug_break(debug_break));

   // 40 MHz core clock
   always #12.5 core_clk = ~core_clk;

   // break pulse count; the cycle ceiling cuts a hung handshake short
   always @(posedge core_clk)
   begin
      cycles++;
      if (debug_break === 1'b1)
         breaks++;
      if (cycles == 20000)
      begin
         num_errors++;
         end_of_test();
      end
   end

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic end_of_test();
   begin
      $display("checked %0d values, %0d errors", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   end
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
   begin
      samples_checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   end
   endtask

   // one avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
   begin
      @(posedge core_clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      // no local limit: only the cycle ceiling ends a wait
      do
      begin
         @(posedge core_clk);
      end
      while (avs_waitrequest !== 1'b0);
      rd_q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   end
   endtask

   task automatic setreg(input logic [4:0] r, input logic [7:0] v);
   begin
      bus(1'b1, cskb_pkg::REG_GPR_SEL, {27'h0, r});
      bus(1'b1, cskb_pkg::REG_GPR_DATA, {24'h0, v});
   end
   endtask

   task automatic prep(input logic [7:0] fl);
   begin
      bus(1'b1, cskb_pkg::REG_PC, 32'h0000_0100);
      bus(1'b1, cskb_pkg::REG_STATUS_FLAGS, {24'h0, fl});
   end
   endtask

   function automatic logic [31:0] ins(logic [4:0] op, logic [4:0] rd, logic [4:0] rr,
      logic [2:0] b, logic [7:0] k, logic two);
      return {5'h00, two, k, b, rr, rd, op};
   endfunction

   // write the instruction, then poll busy until it reads zero; only the cycle ceiling bounds the poll
   task automatic exec(input logic [31:0] word);
   begin
      bus(1'b1, cskb_pkg::REG_INSTR, word);
      do
      begin
         bus(1'b0, cskb_pkg::REG_BUSY, 32'h0);
      end
      while (rd_q[0] !== 1'b0);
   end
   endtask

   task automatic look(input logic [15:0] pc, input logic [1:0] cyc, input logic [7:0] fl);
   begin
      bus(1'b0, cskb_pkg::REG_PC, 32'h0);
      check(rd_q, {16'h0, pc});
      bus(1'b0, cskb_pkg::REG_CYCLES, 32'h0);
      check(rd_q, {30'h0, cyc});
      bus(1'b0, cskb_pkg::REG_STATUS_FLAGS, 32'h0);
      check(rd_q, {24'h0, fl});
   end
   endtask

   // branch condition per opcode, indexed from the first branch opcode
   function automatic logic cond(logic [4:0] op, logic [7:0] f, logic [2:0] s);
      logic [14:0] t;
      t = {!f[6], f[6], f[5], f[2] ^ f[3], !(f[2] ^ f[3]), !f[2], f[2], f[0], !f[0],
         !f[0], f[0], !f[1], f[1], !f[s], f[s]};
      return t[op - cskb_pkg::OP_BRANCH_STATUS_BIT_SET];
   endfunction

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset();
   begin
      bus(1'b0, cskb_pkg::REG_STACK_PTR, 32'h0);
      check(rd_q, 32'h0000_00FF);
      bus(1'b1, 4'hB, 32'h0000_00AA);
      bus(1'b0, 4'hB, 32'h0);
      check(rd_q, 32'h0);
   end
   endtask

   task automatic t_compare();
   begin
      setreg(5'h01, 8'h10);
      setreg(5'h02, 8'h20);
      prep(8'h00);
      exec(ins(cskb_pkg::OP_COMPARE_REGS, 5'h01, 5'h02, 3'h0, 8'h00, 1'b0));
      look(16'h0101, 2'h1, 8'h05);
      setreg(5'h02, 8'h0F);
      prep(8'h01);
      exec(ins(cskb_pkg::OP_COMPARE_REGS_WITH_CARRY, 5'h01, 5'h02, 3'h0, 8'h00, 1'b0));
      look(16'h0101, 2'h1, 8'h22);
      prep(8'h10);
      exec(ins(cskb_pkg::OP_COMPARE_IMMEDIATE, 5'h01, 5'h00, 3'h0, 8'h80, 1'b0));
      look(16'h0101, 2'h1, 8'h1D);
      // compares never write back, so r1 keeps its value
      bus(1'b1, cskb_pkg::REG_GPR_SEL, 32'h0000_0001);
      bus(1'b0, cskb_pkg::REG_GPR_DATA, 32'h0);
      check(rd_q, 32'h0000_0010);
   end
   endtask

   task automatic t_skips();
      logic tk;
      logic [7:0] v;
   begin
      for (logic [4:0] op = cskb_pkg::OP_COMPARE_SKIP_EQUAL;
         op <= cskb_pkg::OP_SKIP_IO_BIT_SET; op++)
         for (int j = 0; j < 4; j++)
         begin
            v = j[0] ? 8'h08 : 8'h00;
            tk = (op == cskb_pkg::OP_SKIP_REG_BIT_CLEAR ||
               op == cskb_pkg::OP_SKIP_IO_BIT_CLEAR) ? !j[0] : j[0];
            setreg(5'h04, v);
            setreg(5'h05, 8'h08);
            io_data <= v;
            prep(8'h6B);
            exec(ins(op, 5'h04, 5'h05, 3'h3, 8'h00, j[1]));
            look(tk ? 16'h0102 + j[1] : 16'h0101, tk ? 2'h2 + j[1] : 2'h1, 8'h6B);
            check({27'h0, io_addr}, 32'h4);
         end
   end
   endtask

   task automatic t_branches();
      logic [7:0] fl;
      logic [7:0] k;
      logic tk;
   begin
      for (logic [4:0] op = cskb_pkg::OP_BRANCH_STATUS_BIT_SET;
         op <= cskb_pkg::OP_BRANCH_TRANSFER_BIT_CLEAR; op++)
         for (int j = 0; j < 4; j++)
         begin
            fl = (j == 0) ? 8'h00 : (j == 1) ? 8'h6F : (j == 2) ? 8'h04 : 8'h08;
            k = j[0] ? 8'h7E : 8'h3F;
            tk = cond(op, fl, 3'(j * 2 + 1));
            prep(fl);
            exec(ins(op, 5'h00, 5'h00, 3'(j * 2 + 1), k, 1'b0));
            look(tk ? 16'h0101 + {{9{k[6]}}, k[6:0]} : 16'h0101, tk ? 2'h2 : 2'h1, fl);
         end
   end
   endtask

   task automatic t_stack();
   begin
      setreg(5'h03, 8'hA5);
      prep(8'h3C);
      // freeze the core mid-instruction; the push must still count two cycles
      bus(1'b1, cskb_pkg::REG_INSTR, ins(cskb_pkg::OP_PUSH, 5'h03, 5'h00, 3'h0, 8'h00, 1'b0));
      clk_en <= 1'b0;
      repeat (4) @(posedge core_clk);
      clk_en <= 1'b1;
      do
      begin
         bus(1'b0, cskb_pkg::REG_BUSY, 32'h0);
      end
      while (rd_q[0] !== 1'b0);
      look(16'h0101, 2'h2, 8'h3C);
      bus(1'b0, cskb_pkg::REG_STACK_PTR, 32'h0);
      check(rd_q, 32'h0000_00FE);
      setreg(5'h03, 8'h00);
      prep(8'h3C);
      exec(ins(cskb_pkg::OP_POP, 5'h03, 5'h00, 3'h0, 8'h00, 1'b0));
      look(16'h0101, 2'h2, 8'h3C);
      bus(1'b0, cskb_pkg::REG_GPR_DATA, 32'h0);
      check(rd_q, 32'h0000_00A5);
   end
   endtask

   task automatic t_break();
   begin
      prep(8'h55);
      breaks = 0;
      exec(ins(cskb_pkg::OP_DEBUG_BREAK, 5'h00, 5'h00, 3'h0, 8'h00, 1'b0));
      look(16'h0101, 2'h1, 8'h55);
      check(32'(breaks), 32'h1);
   end
   endtask

   // reset for five cycles, then run every scenario
   initial
   begin
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_compare();
      t_skips();
      t_branches();
      t_stack();
      t_break();
      end_of_test();
   end
endmodule // test_cskb_unit
